// file: common/smbus_arp_pkg.sv
// Constants, encodings and the checksum function of the SMBus ARP target
// Behaviour
// - Bus variant, ARP-capable or fixed-and-discoverable, is chosen by the position strap.
// - ARP-capable variant takes part in address resolution for dynamic addressing.
// - Fixed variant answers a strap-derived fixed address from power-up, SMBus 1.x compatible.
// - Strap is sampled once at power-up and decoded into one of eight levels.
// - Decoded strap level is held; later strap changes are ignored until power cycle.
// - ARP-capable mode provides a 128-bit unique identifier returned to the host.
// - Low 16 bits of the vendor-specific identifier part come from an internal random number generator.
// - Power-up strap level is included in the unique identifier.
// - General ARP commands always accepted, except Get UDID while the address is resolved; directed ones only at the established address.
// - Every ARP exchange carries a checksum byte; device checks and generates it.
// - Supports Prepare and Assign general; Reset and Get UDID general and directed.
// - Four highest strap levels select ARP mode, position bits 111 down to 100.
// - Four lowest strap levels select fixed mode, addresses 0x53 down to 0x50.
// - First data byte of a write to the device address is stored in the register select pointer.
// - Fixed mode keeps its strap address; Assign Address does not change it.
// - Vendor-specific field holds position bits then a 16-bit random value.
package smbus_arp_pkg;

   //------------------------------------------------------------
   // Addresses and strap decode
   //------------------------------------------------------------
   localparam logic [6:0] DEFAULT_ADDR    = 7'h61;
   localparam logic [6:0] FIXED_ADDR_BASE = 7'h50;
   localparam logic [2:0] ARP_LEVEL_MIN   = 3'h4;
   localparam logic [7:0] NO_ADDR_BYTE    = 8'hff;
   localparam logic [7:0] IDLE_BYTE       = 8'hff;

   //------------------------------------------------------------
   // ARP commands and transaction layout
   //------------------------------------------------------------
   localparam logic [7:0] CMD_PREPARE     = 8'h01;
   localparam logic [7:0] CMD_RESET       = 8'h02;
   localparam logic [7:0] CMD_GET_UDID    = 8'h03;
   localparam logic [7:0] CMD_ASSIGN      = 8'h04;
   localparam logic [7:0] UDID_COUNT      = 8'h11;
   localparam logic [4:0] WR_IDX_CMD      = 5'h00;
   localparam logic [4:0] WR_IDX_UDID0    = 5'h02;
   localparam logic [4:0] WR_IDX_NEW_ADDR = 5'h12;
   localparam logic [4:0] SHORT_CMD_BYTES = 5'h02;
   localparam logic [4:0] ASSIGN_BYTES    = 5'h14;
   localparam logic [4:0] RD_IDX_COUNT    = 5'h00;
   localparam logic [4:0] RD_IDX_UDID0    = 5'h01;
   localparam logic [4:0] RD_IDX_ADDR     = 5'h11;
   localparam logic [4:0] RD_IDX_PEC      = 5'h12;

   //------------------------------------------------------------
   // Identifier fields and checksum
   //------------------------------------------------------------
   localparam logic [7:0]  UDID_VERSION   = 8'h0a;
   localparam logic [15:0] UDID_INTERFACE = 16'h0004;
   localparam logic [15:0] UDID_SUBSYS    = 16'h0000;
   localparam logic [12:0] VS_ZERO        = 13'h0000;
   localparam logic [7:0]  PEC_POLY       = 8'h07;
   localparam logic [15:0] LFSR_SEED      = 16'hace1;
   localparam logic [2:0]  BIT_LAST       = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
   } bus_state_t;

   function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc8

endpackage : smbus_arp_pkg

// file: rtl/smbus_arp_slave.sv
// SMBus target with ARP, fixed-address mode and register select pointer
`timescale 1ns/1ps
module smbus_arp_slave #(
   parameter logic [7:0]  UDID_CAPS      = 8'h41,   // Arbitrary value
   parameter logic [15:0] UDID_VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] UDID_DEVICE_ID = 16'h5678  // Arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic [2:0]  board_position_strap_i,
   input  wire logic [7:0]  rd_data_i,
   output logic [7:0]       register_select_pointer_o,
   output logic [7:0]       wr_data_o,
   output logic             wr_stb_o,
   output logic             rd_stb_o,
   output logic             fixed_discoverable_mode_o,
   output logic [6:0]       dev_addr_o,
   output logic             addr_valid_o
);

   //------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------
   logic [2:0] scl_s_reg, scl_s_next, sda_s_reg, sda_s_next;
   logic       scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
   logic       scl_p_reg, sda_p_reg;

   always_comb begin
      scl_s_next = {scl_s_reg[1:0], scl_i};
      sda_s_next = {sda_s_reg[1:0], sda_i};
      scl_q_next = (scl_s_reg[1] == scl_s_reg[2]) ? scl_s_reg[2] : scl_q_reg;
      sda_q_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_q_reg;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_s_reg <= 3'h7;
         sda_s_reg <= 3'h7;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else if (ce_i) begin
         scl_s_reg <= scl_s_next;
         sda_s_reg <= sda_s_next;
         scl_q_reg <= scl_q_next;
         sda_q_reg <= sda_q_next;
         scl_p_reg <= scl_q_reg;
         sda_p_reg <= sda_q_reg;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_q_reg & ~scl_p_reg;
   assign scl_fall  = ~scl_q_reg & scl_p_reg;
   assign bus_start = scl_q_reg & scl_p_reg & ~sda_q_reg & sda_p_reg;
   assign bus_stop  = scl_q_reg & scl_p_reg & sda_q_reg & ~sda_p_reg;

   //------------------------------------------------------------
   // Strap and identifier
   //------------------------------------------------------------
   logic        fd_mode;
   logic [2:0]  position;
   logic [6:0]  fixed_addr;
   logic [15:0] rand_val;

   strap_rng u_strap_rng (
      .clk_i                     (clk_i),
      .srst_i                    (srst_i),
      .ce_i                      (ce_i),
      .board_position_strap_i    (board_position_strap_i),
      .seed_take_i               (bus_start),
      .fixed_discoverable_mode_o (fd_mode),
      .position_id_bits_o        (position),
      .fixed_addr_o              (fixed_addr),
      .rand_o                    (rand_val)
   );

   logic [127:0] udid;
   assign udid = {UDID_CAPS, smbus_arp_pkg::UDID_VERSION, UDID_VENDOR_ID, UDID_DEVICE_ID,
                  smbus_arp_pkg::UDID_INTERFACE, smbus_arp_pkg::UDID_SUBSYS, smbus_arp_pkg::UDID_SUBSYS,
                  smbus_arp_pkg::VS_ZERO, position, rand_val};

   function automatic logic [7:0] udid_byte(input logic [127:0] u, input logic [4:0] k);
      logic [127:0] t;
      t = u << {k, 3'b000};
      return t[127:120];
   endfunction : udid_byte

   //------------------------------------------------------------
   // Protocol engine
   //------------------------------------------------------------
   smbus_arp_pkg::bus_state_t state_reg, state_next;
   logic [2:0] bit_reg,   bit_next;
   logic [1:0] phase_reg, phase_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_reg,    tx_next;
   logic [7:0] crc_reg,   crc_next;
   logic [7:0] cmd_reg,   cmd_next;
   logic [4:0] idx_reg,   idx_next;
   logic       arp_reg,   arp_next;
   logic       rw_reg,    rw_next;
   logic       drive_reg, drive_next;
   logic       match_reg, match_next;
   logic [6:0] new_reg,   new_next;
   logic [6:0] asg_reg,   asg_next;
   logic       av_reg,    av_next;
   logic       ar_reg,    ar_next;
   logic [7:0] ptr_reg,   ptr_next;
   logic [7:0] wd_reg,    wd_next;
   logic       wstb_reg,  wstb_next;
   logic       rstb_reg,  rstb_next;

   logic [6:0] my_addr;
   logic       my_valid;
   logic [7:0] rx_byte, tx_byte;
   logic       directed;

   assign my_addr  = fd_mode ? fixed_addr : asg_reg;
   assign my_valid = fd_mode | av_reg;
   assign rx_byte  = {shift_reg[6:0], sda_q_reg};
   assign directed = my_valid && (cmd_reg[7:1] == my_addr);

   // Byte to send in the next read slot; ARP answers only to an accepted Get UDID
   always_comb begin
      tx_byte = smbus_arp_pkg::IDLE_BYTE;
      if (!arp_reg) begin
         tx_byte = rd_data_i;
      end else if ((cmd_reg == smbus_arp_pkg::CMD_GET_UDID && !ar_reg) || (directed && cmd_reg[0])) begin
         if (idx_reg == smbus_arp_pkg::RD_IDX_COUNT) begin
            tx_byte = smbus_arp_pkg::UDID_COUNT;
         end else if (idx_reg < smbus_arp_pkg::RD_IDX_ADDR) begin
            tx_byte = udid_byte(udid, idx_reg - smbus_arp_pkg::RD_IDX_UDID0);
         end else if (idx_reg == smbus_arp_pkg::RD_IDX_ADDR) begin
            tx_byte = my_valid ? {my_addr, 1'b1} : smbus_arp_pkg::NO_ADDR_BYTE;
         end else if (idx_reg == smbus_arp_pkg::RD_IDX_PEC) begin
            tx_byte = crc_reg;
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      bit_next   = bit_reg;
      phase_next = phase_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      crc_next   = crc_reg;
      cmd_next   = cmd_reg;
      idx_next   = idx_reg;
      arp_next   = arp_reg;
      rw_next    = rw_reg;
      drive_next = drive_reg;
      match_next = match_reg;
      new_next   = new_reg;
      asg_next   = asg_reg;
      av_next    = av_reg;
      ar_next    = ar_reg;
      ptr_next   = ptr_reg;
      wd_next    = wd_reg;
      wstb_next  = 1'b0;
      rstb_next  = 1'b0;
      if (bus_stop) begin
         state_next = smbus_arp_pkg::ST_IDLE;
         drive_next = 1'b0;
         // Commands act only on a complete frame with a good checksum
         if (arp_reg && !rw_reg && crc_reg == 8'h00 && state_reg == smbus_arp_pkg::ST_WRITE) begin
            if (idx_reg == smbus_arp_pkg::SHORT_CMD_BYTES) begin
               if (cmd_reg == smbus_arp_pkg::CMD_PREPARE) begin
                  ar_next = 1'b0;
               end else if (cmd_reg == smbus_arp_pkg::CMD_RESET || (directed && !cmd_reg[0])) begin
                  ar_next = 1'b0;
                  av_next = 1'b0;
               end
            end else if (idx_reg == smbus_arp_pkg::ASSIGN_BYTES && cmd_reg == smbus_arp_pkg::CMD_ASSIGN
                         && match_reg) begin
               ar_next = 1'b1;
               if (!fd_mode) begin
                  asg_next = new_reg;
                  av_next  = 1'b1;
               end
            end
         end
      end else if (bus_start) begin
         if (state_reg == smbus_arp_pkg::ST_IDLE) begin
            crc_next = 8'h00;
         end
         state_next = smbus_arp_pkg::ST_ADDR;
         bit_next   = 3'h0;
         idx_next   = 5'h00;
         drive_next = 1'b0;
      end else begin
         case (state_reg)
            smbus_arp_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift_next = rx_byte;
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == smbus_arp_pkg::BIT_LAST) begin
                     crc_next   = smbus_arp_pkg::crc8(crc_reg, rx_byte);
                     rw_next    = sda_q_reg;
                     arp_next   = (shift_reg[6:0] == smbus_arp_pkg::DEFAULT_ADDR);
                     phase_next = 2'h0;
                     if (shift_reg[6:0] == smbus_arp_pkg::DEFAULT_ADDR || (my_valid && shift_reg[6:0] == my_addr)) begin
                        state_next = smbus_arp_pkg::ST_ADDR_ACK;
                     end else begin
                        state_next = smbus_arp_pkg::ST_IDLE;
                     end
                  end
               end
            end
            smbus_arp_pkg::ST_ADDR_ACK, smbus_arp_pkg::ST_WRITE_ACK: begin
               if (scl_fall) begin
                  if (phase_reg == 2'h0) begin
                     drive_next = 1'b1;
                     phase_next = 2'h1;
                  end else if (rw_reg) begin
                     tx_next    = {tx_byte[6:0], 1'b0};
                     drive_next = ~tx_byte[7];
                     crc_next   = smbus_arp_pkg::crc8(crc_reg, tx_byte);
                     rstb_next  = ~arp_reg;
                     bit_next   = 3'h0;
                     state_next = smbus_arp_pkg::ST_READ;
                  end else begin
                     drive_next = 1'b0;
                     bit_next   = 3'h0;
                     state_next = smbus_arp_pkg::ST_WRITE;
                  end
               end
            end
            smbus_arp_pkg::ST_WRITE: begin
               if (scl_rise) begin
                  shift_next = rx_byte;
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == smbus_arp_pkg::BIT_LAST) begin
                     crc_next   = smbus_arp_pkg::crc8(crc_reg, rx_byte);
                     idx_next   = idx_reg + 5'h01;
                     phase_next = 2'h0;
                     state_next = smbus_arp_pkg::ST_WRITE_ACK;
                     if (arp_reg) begin
                        if (idx_reg == smbus_arp_pkg::WR_IDX_CMD) begin
                           cmd_next   = rx_byte;
                           match_next = 1'b1;
                        end else if (idx_reg >= smbus_arp_pkg::WR_IDX_UDID0 && idx_reg < smbus_arp_pkg::WR_IDX_NEW_ADDR
                                     && rx_byte != udid_byte(udid, idx_reg - smbus_arp_pkg::WR_IDX_UDID0)) begin
                           match_next = 1'b0;
                        end else if (idx_reg == smbus_arp_pkg::WR_IDX_NEW_ADDR) begin
                           new_next = rx_byte[7:1];
                        end
                     end else if (idx_reg == smbus_arp_pkg::WR_IDX_CMD) begin
                        ptr_next = rx_byte;
                     end else begin
                        wd_next   = rx_byte;
                        wstb_next = 1'b1;
                     end
                  end
               end
            end
            smbus_arp_pkg::ST_READ: begin
               if (scl_rise) begin
                  bit_next = bit_reg + 3'h1;
                  if (bit_reg == smbus_arp_pkg::BIT_LAST) begin
                     idx_next   = idx_reg + 5'h01;
                     phase_next = 2'h0;
                     state_next = smbus_arp_pkg::ST_READ_ACK;
                  end
               end else if (scl_fall) begin
                  drive_next = ~tx_reg[7];
                  tx_next    = {tx_reg[6:0], 1'b0};
               end
            end
            smbus_arp_pkg::ST_READ_ACK: begin
               if (scl_fall && phase_reg == 2'h0) begin
                  drive_next = 1'b0;
                  phase_next = 2'h1;
               end else if (scl_rise && phase_reg == 2'h1) begin
                  // Master NACK ends the read; wait for stop
                  if (sda_q_reg) begin
                     state_next = smbus_arp_pkg::ST_IDLE;
                  end else begin
                     phase_next = 2'h1;
                     rw_next    = 1'b1;
                     state_next = smbus_arp_pkg::ST_ADDR_ACK;
                  end
               end
            end
            default: begin
               drive_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= smbus_arp_pkg::ST_IDLE;
         bit_reg   <= 3'h0;
         phase_reg <= 2'h0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'h00;
         crc_reg   <= 8'h00;
         cmd_reg   <= 8'h00;
         idx_reg   <= 5'h00;
         arp_reg   <= 1'b0;
         rw_reg    <= 1'b0;
         drive_reg <= 1'b0;
         match_reg <= 1'b0;
         new_reg   <= 7'h00;
         asg_reg   <= 7'h00;
         av_reg    <= 1'b0;
         ar_reg    <= 1'b0;
         ptr_reg   <= 8'h00;
         wd_reg    <= 8'h00;
         wstb_reg  <= 1'b0;
         rstb_reg  <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         bit_reg   <= bit_next;
         phase_reg <= phase_next;
         shift_reg <= shift_next;
         tx_reg    <= tx_next;
         crc_reg   <= crc_next;
         cmd_reg   <= cmd_next;
         idx_reg   <= idx_next;
         arp_reg   <= arp_next;
         rw_reg    <= rw_next;
         drive_reg <= drive_next;
         match_reg <= match_next;
         new_reg   <= new_next;
         asg_reg   <= asg_next;
         av_reg    <= av_next;
         ar_reg    <= ar_next;
         ptr_reg   <= ptr_next;
         wd_reg    <= wd_next;
         wstb_reg  <= wstb_next;
         rstb_reg  <= rstb_next;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign sda_o                     = 1'b0;
   assign sda_oe_o                  = drive_reg;
   assign register_select_pointer_o = ptr_reg;
   assign wr_data_o                 = wd_reg;
   assign wr_stb_o                  = wstb_reg;
   assign rd_stb_o                  = rstb_reg;
   assign fixed_discoverable_mode_o = fd_mode;
   assign dev_addr_o                = my_addr;
   assign addr_valid_o              = my_valid;

endmodule : smbus_arp_slave

// file: rtl/strap_rng.sv
// Power-up strap capture, strap decode and random identifier source
`timescale 1ns/1ps
module strap_rng (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   input  wire logic [2:0]  board_position_strap_i,
   input  wire logic        seed_take_i,
   output logic             fixed_discoverable_mode_o,
   output logic [2:0]       position_id_bits_o,
   output logic [6:0]       fixed_addr_o,
   output logic [15:0]      rand_o
);

   logic [2:0]  level_reg,  level_next;
   logic        taken_reg,  taken_next;
   logic [15:0] lfsr_reg,   lfsr_next;
   logic [15:0] rand_reg,   rand_next;
   logic        seeded_reg, seeded_next;

   //------------------------------------------------------------
   // Capture and free-running generator
   //------------------------------------------------------------
   always_comb begin
      level_next  = level_reg;
      taken_next  = 1'b1;
      seeded_next = seeded_reg;
      rand_next   = rand_reg;
      if (!taken_reg) begin
         level_next = board_position_strap_i;
      end
      lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      // Frozen at first bus start: its arrival time differs between boards
      if (seed_take_i && !seeded_reg) begin
         rand_next   = lfsr_reg;
         seeded_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         level_reg  <= 3'h0;
         taken_reg  <= 1'b0;
         lfsr_reg   <= smbus_arp_pkg::LFSR_SEED;
         rand_reg   <= smbus_arp_pkg::LFSR_SEED;
         seeded_reg <= 1'b0;
      end else if (ce_i) begin
         level_reg  <= level_next;
         taken_reg  <= taken_next;
         lfsr_reg   <= lfsr_next;
         rand_reg   <= rand_next;
         seeded_reg <= seeded_next;
      end
   end

   //------------------------------------------------------------
   // Level decode
   //------------------------------------------------------------
   assign fixed_discoverable_mode_o = (level_reg < smbus_arp_pkg::ARP_LEVEL_MIN);
   assign position_id_bits_o        = level_reg;
   assign fixed_addr_o              = smbus_arp_pkg::FIXED_ADDR_BASE + {5'h00, level_reg[1:0]};
   assign rand_o                    = rand_reg;

endmodule : strap_rng

// file: verif/smbus_arp_props.sv
// Concurrent checks on the SMBus ARP target ports
`timescale 1ns/1ps
module smbus_arp_props (
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       scl_i,
   input wire logic       sda_oe_o,
   input wire logic       fixed_discoverable_mode_o,
   input wire logic [6:0] dev_addr_o,
   input wire logic       addr_valid_o,
   input wire logic [7:0] register_select_pointer_o,
   input wire logic [7:0] wr_data_o,
   input wire logic       wr_stb_o,
   input wire logic       rd_stb_o
);
   logic [1:0] run_reg;
   logic [1:0] run_next;
   logic       settled;
   // Strap flop loads on the first edge out of reset, so trust outputs only after two
   always_comb run_next = (run_reg == 2'h2) ? run_reg : run_reg + 2'h1;
   always_ff @(posedge clk_i) run_reg <= srst_i ? 2'h0 : run_next;
   assign settled = (run_reg == 2'h2);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_pulse(sig); sig ##1 !sig; endsequence
   strap_hold_a: assert property (settled |-> $stable(fixed_discoverable_mode_o))
      else $error("mode moved");
   fixed_addr_a: assert property (settled && fixed_discoverable_mode_o |->
      dev_addr_o[6:2] == 5'h14 && addr_valid_o) else $error("fixed address wrong");
   addr_keep_a: assert property (settled && $changed(dev_addr_o) |-> !fixed_discoverable_mode_o)
      else $error("fixed address moved");
   sda_low_scl_a: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data moved while clock high");
   wr_pulse_a: assert property (wr_stb_o |-> s_pulse(wr_stb_o)) else $error("write strobe long");
   wr_data_stb_a: assert property (settled && $changed(wr_data_o) |-> wr_stb_o)
      else $error("data without strobe");
   ptr_load_a: assert property (settled && $changed(register_select_pointer_o) |-> scl_i && !wr_stb_o)
      else $error("pointer load misplaced");
   rd_pulse_a: assert property (rd_stb_o |=> !rd_stb_o) else $error("read strobe long");
endmodule : smbus_arp_props

// file: verif/smbus_host.sv
// Behavioural SMBus host driving the clock and the open-drain data line
`timescale 1ns/1ps
module smbus_host (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic half();
      repeat (8) @(posedge clk_i);
   endtask : half
   // Data moves two cycles after the clock falls so the filter never sees a false start
   task automatic bit_x(input logic b, output logic r);
      repeat (2) @(posedge clk_i);
      sda_o <= b;
      repeat (6) @(posedge clk_i);
      scl_o <= 1'b1;
      half();
      r = sda_i;
      scl_o <= 1'b0;
   endtask : bit_x
   task automatic start();
      repeat (2) @(posedge clk_i);
      sda_o <= 1'b1;
      half();
      scl_o <= 1'b1;
      half();
      sda_o <= 1'b0;
      half();
      scl_o <= 1'b0;
   endtask : start
   task automatic stop();
      repeat (2) @(posedge clk_i);
      sda_o <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      sda_o <= 1'b1;
      half();
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(m, a);
   endtask : xfer
endmodule : smbus_host

// file: verif/testbench.sv
// Self-checking bench for the SMBus ARP target with strap decode
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0]  CAPS = 8'h41;   // Arbitrary value
   localparam logic [15:0] VID  = 16'h2b6e; // Arbitrary value
   localparam logic [15:0] DID  = 16'h7c19; // Arbitrary value
   localparam logic [6:0]  NEW_ADDR = 7'h3a;
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [7:0] rd_data = 8'h00;
   logic       scl, hsda, sda, sdo, sda_oe, fdm, av, wr_stb, rd_stb, a;
   logic [6:0] dev;
   logic [7:0] ptr, wdat, q, pec, p, d;
   logic [7:0] u [16];
   int         ex [$];
   int         fails = 0, tests_run = 0, cyc = 0, nr = 0, seed = 32'h92a3;
   assign sda = hsda & (~sda_oe | sdo);
   initial forever #20 clk_i = ~clk_i;
   smbus_host i_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
   smbus_arp_slave #(.UDID_CAPS(CAPS), .UDID_VENDOR_ID(VID), .UDID_DEVICE_ID(DID)) i_dut (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe),
      .board_position_strap_i(strap), .rd_data_i(rd_data), .register_select_pointer_o(ptr), .wr_data_o(wdat),
      .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .fixed_discoverable_mode_o(fdm), .dev_addr_o(dev), .addr_valid_o(av));
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] v);
      logic [7:0] r;
      r = c ^ v;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ smbus_arp_pkg::PEC_POLY : {r[6:0], 1'b0};
      return r;
   endfunction : crc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic rst(input logic [2:0] l);
      @(posedge clk_i);
      strap <= l;
      srst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : rst
   task automatic send(input logic [7:0] v);
      i_host.xfer(v, 1'b1, q, a);
      pec = crc(pec, v);
   endtask : send
   task automatic cmd(input logic [7:0] c);
      pec = 8'h00;
      i_host.start();
      send(8'hc2);
      send(c);
      send(pec);
      i_host.stop();
      repeat (4) @(posedge clk_i);
   endtask : cmd
   task automatic get_udid(input logic [7:0] c, input logic [7:0] ab);
      ex[14] = int'(strap);
      ex[17] = int'(ab);
      pec = 8'h00;
      i_host.start();
      send(8'hc2);
      send(c);
      i_host.start();
      send(8'hc3);
      for (int i = 0; i < 19; i++) begin
         i_host.xfer(8'hff, i == 18, q, a);
         if (i == 18) chk(q, pec);
         else if (ex[i] >= 0) chk(q, 8'(ex[i]));
         pec = crc(pec, q);
         if (i > 0 && i < 17) u[i - 1] = q;
      end
      i_host.stop();
   endtask : get_udid
   task automatic assign_addr();
      pec = 8'h00;
      i_host.start();
      send(8'hc2);
      send(smbus_arp_pkg::CMD_ASSIGN);
      send(8'h11);
      for (int i = 0; i < 16; i++) send(u[i]);
      send({NEW_ADDR, 1'b0});
      send(pec);
      i_host.stop();
      repeat (4) @(posedge clk_i);
   endtask : assign_addr
   always @(posedge clk_i) begin
      cyc++;
      nr += int'(rd_stb);
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      for (int l = 0; l < 8; l++) begin
         rst(3'(l));
         chk({7'h0, fdm}, {7'h0, l < 4});
         if (l < 4) chk({av, dev}, 8'h80 | 8'(8'h50 + l));
         strap <= ~strap;
         repeat (6) @(posedge clk_i);
         chk({7'h0, fdm}, {7'h0, l < 4});
      end
      ex = '{8'h11, CAPS, 8'h0a, VID[15:8], VID[7:0], DID[15:8], DID[7:0], 0, 4, 0, 0, 0, 0, 0, 5, -1, -1, 8'hff};
      rst(3'h2);
      get_udid(smbus_arp_pkg::CMD_GET_UDID, 8'ha5);
      assign_addr();
      chk({av, dev}, 8'hd2);
      rst(3'h5);
      rd_data <= 8'($random(seed));
      cmd(smbus_arp_pkg::CMD_PREPARE);
      cmd(smbus_arp_pkg::CMD_RESET);
      get_udid(smbus_arp_pkg::CMD_GET_UDID, 8'hff);
      assign_addr();
      chk({av, dev}, {1'b1, NEW_ADDR});
      get_udid({NEW_ADDR, 1'b1}, {NEW_ADDR, 1'b1});
      p = 8'($random(seed));
      d = 8'($random(seed));
      i_host.start();
      send({NEW_ADDR + 7'h1, 1'b0});
      chk({7'h0, a}, 8'h01);
      i_host.start();
      send({NEW_ADDR, 1'b0});
      send(p);
      send(d);
      i_host.stop();
      chk(ptr, p);
      chk(wdat, d);
      i_host.start();
      send({NEW_ADDR, 1'b1});
      i_host.xfer(8'hff, 1'b1, q, a);
      i_host.stop();
      chk(q, rd_data);
      chk(8'(nr), 8'h01);
      cmd({NEW_ADDR, 1'b0});
      chk({7'h0, av}, 8'h00);
      end_sim();
   end
endmodule : testbench
bind smbus_arp_slave smbus_arp_props i_props (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
   .fixed_discoverable_mode_o(fixed_discoverable_mode_o), .dev_addr_o(dev_addr_o), .addr_valid_o(addr_valid_o),
   .register_select_pointer_o(register_select_pointer_o), .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o),
   .rd_stb_o(rd_stb_o));
